// *** pmp_pkg.sv ***
// package for the physical memory protection checker: field layout,
// reset values, access kinds and the request/answer carriers.
// assumes a 64-bit hart with eight protection entries.
package pmp_pkg;

    localparam int unsigned NUM_ENTRIES    = 8;       // protection entries
    localparam int unsigned PADDR_W        = 56;      // physical address width
    localparam int unsigned ADDR_REG_MSB   = 53;      // stored bits [53:0] = paddr[55:2]
    localparam int unsigned CFG_W          = 8;       // one configuration field
    localparam int unsigned CFG_R_BIT      = 0;       // read permission
    localparam int unsigned CFG_W_BIT      = 1;       // write permission
    localparam int unsigned CFG_X_BIT      = 2;       // execute permission
    localparam int unsigned CFG_A_LSB      = 3;       // matching mode low bit
    localparam int unsigned CFG_A_MSB      = 4;       // matching mode high bit
    localparam int unsigned CFG_L_BIT      = 7;       // lock bit
    localparam logic [7:0]  CFG_RESET      = 8'h00;   // mode and lock cleared
    localparam logic [63:0] ADDR_RESET     = 64'h0;   // address register after reset
    localparam logic [1:0]  MODE_OFF       = 2'h0;    // entry disabled
    localparam logic [1:0]  MODE_TOR       = 2'h1;    // top of range
    localparam logic [1:0]  MODE_NA4       = 2'h2;    // naturally aligned four bytes
    localparam logic [1:0]  MODE_NAPOT     = 2'h3;    // naturally aligned power of two
    localparam logic [1:0]  PRIV_USER      = 2'h0;    // privilege encodings
    localparam logic [1:0]  PRIV_SUPER     = 2'h1;
    localparam logic [1:0]  PRIV_MACHINE   = 2'h3;

    // kinds of access presented for checking
    typedef enum logic [2:0] {
        ACC_LOAD,
        ACC_STORE,
        ACC_FETCH,
        ACC_PTW,
        ACC_FLUSH,
        ACC_DISCARD
    } acc_kind_t;

    // fault reported with an answer
    typedef enum logic [1:0] {
        FAULT_NONE,
        FAULT_LOAD,
        FAULT_STORE,
        FAULT_FETCH
    } fault_t;

    // one access from this hart's pipeline
    typedef struct packed {
        logic [55:0] paddr;      // first byte address
        logic [6:0]  size_m1;    // byte count minus one (flush: line size minus one)
        acc_kind_t   kind;       // access kind
        logic [1:0]  priv;       // effective privilege of the request
        logic        spec;       // speculative fetch, never traps
        logic        reserved;   // address decodes to a reserved hole
        logic        in_device;  // hole lies inside a device's space
    } acc_req_t;

    // verdict for that access
    typedef struct packed {
        logic        grant;      // access may proceed
        fault_t      fault;      // access fault to raise
        logic        zero_read;  // reserved hole: read as zero, drop write
        logic        bus_error;  // reserved space outside devices
        logic [3:0]  entry;      // winning entry, 8 means none
    } acc_resp_t;

    // register write port from the csr unit
    typedef struct packed {
        logic        we;         // write strobe
        logic        is_cfg;     // 1: configuration group, 0: address register
        logic [2:0]  idx;        // address register index
        logic [63:0] wdata;      // written value
    } csr_wr_t;

endpackage

// *** phys_mem_protection_checker.sv ***
// physical memory protection checker for one hart: eight entries, a
// configuration group and address registers, and a one-cycle verdict.
// assumes the csr unit decodes instructions and gives the current privilege;
// accesses of other harts and of front-port masters never reach this block.
//
// Notes on behaviour
// R01: eight address registers, one per config field
// R02: address register holds base shifted right two
// R03: address registers keep physical bits 55:2 only
// R04: register writes accepted only in machine mode
// R05: software writes address, then aligned config
// R06: lowest matching index wins
// R07: partial coverage by winning entry fails
// R08: machine unlocked passes; locked or lower enforce
// R09: denied load/store/fetch raise matching fault
// R10: execute fault reported on target fetch
// R11: any failing part of instruction faults
// R12: split store parts checked independently
// R13: page-table walks checked as supervisor
// R14: speculative non-executable fetch never traps
// R15: software fences after changes under paging
// R16: new settings apply to next access
// R17: checks only this hart's own accesses
// R18: unmatched: machine passes, others fail
// R19: reserved hole inside device reads zero
// R20: reserved space outside devices bus error
// R21: flush over locked line part faults store
// R22: discard never takes write-back fault
// R23: locked entry ignores further writes
// R24: config fields R W X, mode 4:3, lock 7
// R25: mode and lock cleared at reset
// R26: all entries checked in one cycle
`timescale 1ns/1ns
`default_nettype none

module phys_mem_protection_checker #(
    parameter int unsigned ENTRIES = 8      // protection entries
) (
    input  wire logic              sys_clk,   // core clock
    input  wire logic              rst,       // synchronous reset, active high
    input  wire logic [1:0]        cur_priv,  // privilege the hart runs in
    input  wire pmp_pkg::csr_wr_t  csr_wr,    // register write port
    input  wire logic [2:0]        rd_idx,    // address register to read
    output logic [63:0]            rd_addr,   // selected address register
    output logic [63:0]            rd_cfg,    // configuration group
    input  wire logic              req_valid, // access presented this cycle
    input  wire pmp_pkg::acc_req_t req,       // access to check
    output pmp_pkg::acc_resp_t     resp,      // verdict, registered
    output logic                   resp_valid // verdict valid
);

    // only eight entries fit the single configuration group
    if (ENTRIES != pmp_pkg::NUM_ENTRIES)
    begin : g_bad_entries
        $error("ENTRIES must equal eight");
    end

    logic [7:0]  cfg_ff  [ENTRIES];          // configuration fields
    logic [53:0] addr_ff [ENTRIES];          // address registers, paddr[55:2]

    // field helpers
    function automatic logic locked(input logic [7:0] c);
        locked = c[pmp_pkg::CFG_L_BIT];
    endfunction

    function automatic logic [1:0] mode_of(input logic [7:0] c);
        mode_of = c[pmp_pkg::CFG_A_MSB:pmp_pkg::CFG_A_LSB];
    endfunction

    // a locked tor entry also freezes the address below it
    function automatic logic addr_frozen(input int unsigned i, input logic [7:0] c0, input logic [7:0] c1);
        addr_frozen = locked(c0) || (i + 1 < ENTRIES && locked(c1) && mode_of(c1) == pmp_pkg::MODE_TOR);
    endfunction

    // writes: machine mode only, locked entries keep their value
    logic wr_ok;
    assign wr_ok = csr_wr.we && (cur_priv == pmp_pkg::PRIV_MACHINE);   // see R04

    for (genvar i = 0; i < ENTRIES; i++)
    begin : g_regs
        // configuration field i sits in byte i of the group
        always_ff @(posedge sys_clk)
        begin
            if (rst)
                cfg_ff[i] <= pmp_pkg::CFG_RESET;                         // see R25
            else if (wr_ok && csr_wr.is_cfg && !locked(cfg_ff[i]))       // see R23
                cfg_ff[i] <= csr_wr.wdata[i*8 +: 8];                     // see R24
        end

        // address register i, base shifted right two, bits 55:2 kept
        always_ff @(posedge sys_clk)
        begin
            if (rst)
                addr_ff[i] <= pmp_pkg::ADDR_RESET[53:0];
            else if (wr_ok && !csr_wr.is_cfg && csr_wr.idx == 3'(i)
                     && !addr_frozen(i, cfg_ff[i], cfg_ff[(i + 1) % ENTRIES]))   // see R23
                addr_ff[i] <= csr_wr.wdata[pmp_pkg::ADDR_REG_MSB:0];     // see R01 see R02 see R03
        end
    end

    // read back: bits above 55:2 read zero
    always_comb
    begin
        rd_addr = {10'h000, addr_ff[rd_idx]};                            // see R03
        for (int i = 0; i < ENTRIES; i++)
            rd_cfg[i*8 +: 8] = cfg_ff[i];
    end

    // access span in byte-address terms (byte addresses kept 56 bits)
    logic [55:0] lo_b;                       // first byte
    logic [55:0] hi_b;                       // last byte
    assign lo_b = req.paddr;
    assign hi_b = req.paddr + 56'(req.size_m1);

    // per-entry match: any byte inside, all bytes inside
    logic [ENTRIES-1:0] any_hit;
    logic [ENTRIES-1:0] all_hit;

    for (genvar i = 0; i < ENTRIES; i++)
    begin : g_match
        logic [55:0] base_b;                 // region first byte
        logic [55:0] top_b;                  // region first byte past the end
        logic [55:0] mask_b;                 // napot size mask
        logic [55:0] prev_b;                 // tor lower bound
        always_comb
        begin
            // napot mask: trailing ones of the register plus the zero, plus two
            mask_b = {addr_ff[i] ^ (addr_ff[i] + 54'h1), 2'h3};
            prev_b = (i == 0) ? 56'h0 : {addr_ff[(i + ENTRIES - 1) % ENTRIES], 2'h0};
            base_b = {addr_ff[i], 2'h0};
            top_b  = base_b;
            unique case (mode_of(cfg_ff[i]))
                pmp_pkg::MODE_TOR:
                begin
                    base_b = prev_b;                                     // tor: prev <= a < this
                    top_b  = {addr_ff[i], 2'h0};
                end
                pmp_pkg::MODE_NA4:
                    top_b  = base_b + 56'h4;
                pmp_pkg::MODE_NAPOT:
                begin
                    base_b = {addr_ff[i], 2'h0} & ~mask_b;
                    top_b  = base_b + mask_b + 56'h1;
                end
                pmp_pkg::MODE_OFF:
                    top_b  = base_b;                                     // empty range
            endcase
            // overlap and full coverage, all entries in the same cycle
            any_hit[i] = (mode_of(cfg_ff[i]) != pmp_pkg::MODE_OFF)
                         && (hi_b >= base_b) && (lo_b < top_b);          // see R26
            all_hit[i] = any_hit[i] && (lo_b >= base_b) && (hi_b < top_b);   // see R07
        end
    end

    // priority pick of the lowest index touching the access
    logic [3:0] win;
    always_comb
    begin
        win = 4'h8;
        for (int i = ENTRIES - 1; i >= 0; i--)
            if (any_hit[i])
                win = 4'(i);                                             // see R06
    end

    // effective privilege: walks run as supervisor
    logic [1:0] eff_priv;
    assign eff_priv = (req.kind == pmp_pkg::ACC_PTW) ? pmp_pkg::PRIV_SUPER : req.priv;   // see R13

    // locked entries overlapping a flushed line
    logic lock_in_line;
    always_comb
    begin
        lock_in_line = 1'b0;
        for (int i = 0; i < ENTRIES; i++)
            if (any_hit[i] && locked(cfg_ff[i]))
                lock_in_line = 1'b1;
    end

    // verdict, combinational: each part of a split access is its own request,
    // so a passing part proceeds even when its sibling faults
    logic               ok;
    pmp_pkg::fault_t    flt;
    logic [7:0]         wc;                  // winning configuration
    always_comb
    begin
        wc  = (win < 4'h8) ? cfg_ff[win[2:0]] : 8'h00;
        ok  = 1'b0;
        if (win == 4'h8)
            ok = (eff_priv == pmp_pkg::PRIV_MACHINE);                    // see R18
        else if (!all_hit[win[2:0]])
            ok = 1'b0;                                                   // see R07
        else if (eff_priv == pmp_pkg::PRIV_MACHINE && !locked(wc))
            ok = 1'b1;                                                   // see R08
        else
        begin
            unique case (req.kind)
                pmp_pkg::ACC_LOAD,
                pmp_pkg::ACC_PTW:     ok = wc[pmp_pkg::CFG_R_BIT];
                pmp_pkg::ACC_STORE:   ok = wc[pmp_pkg::CFG_W_BIT];
                pmp_pkg::ACC_FETCH:   ok = wc[pmp_pkg::CFG_X_BIT];
                pmp_pkg::ACC_FLUSH:   ok = 1'b1;
                pmp_pkg::ACC_DISCARD: ok = 1'b1;
                default:              ok = 1'b0;                         // illegal kind code
            endcase
        end
        // flush writes back the line: any locked part faults
        if (req.kind == pmp_pkg::ACC_FLUSH)
            ok = !lock_in_line;                                          // see R21
        // discard writes nothing back, so it never faults
        if (req.kind == pmp_pkg::ACC_DISCARD)
            ok = 1'b1;                                                   // see R22
        // fault class by access kind
        flt = pmp_pkg::FAULT_NONE;
        if (!ok)
        begin
            unique case (req.kind)
                pmp_pkg::ACC_LOAD,
                pmp_pkg::ACC_PTW:     flt = pmp_pkg::FAULT_LOAD;         // see R09
                pmp_pkg::ACC_FETCH:   flt = req.spec ? pmp_pkg::FAULT_NONE
                                                     : pmp_pkg::FAULT_FETCH;   // see R10 see R14
                default:              flt = pmp_pkg::FAULT_STORE;        // see R09 see R11 see R12
            endcase
        end
    end

    // registered answer one cycle after the request; settings read live,
    // so a register write is seen by the very next access
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            resp       <= '0;
            resp_valid <= 1'b0;
        end
        else
        begin
            resp_valid      <= req_valid;                                // see R16 see R17
            resp.grant      <= req_valid && ok && !(req.reserved && !req.in_device);
            resp.fault      <= req_valid ? flt : pmp_pkg::FAULT_NONE;
            resp.entry      <= win;
            resp.zero_read  <= req_valid && ok && req.reserved && req.in_device;    // see R19
            resp.bus_error  <= req_valid && ok && req.reserved && !req.in_device;   // see R20
        end
    end

endmodule

`default_nettype wire

// *** pmp_check_asserts.sv ***
// checker for the protection block: verdict timing, register guarding and verdict shapes.
// assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module pmp_check_asserts #(
    parameter int unsigned ENTRIES = 8         // protection entries
) (
    input wire logic               sys_clk,    // core clock
    input wire logic               rst,        // sync reset, active high
    input wire logic [1:0]         cur_priv,   // hart privilege
    input wire pmp_pkg::csr_wr_t   csr_wr,     // register writes
    input wire logic [2:0]         rd_idx,     // readback select
    input wire logic [63:0]        rd_addr,    // address readback
    input wire logic [63:0]        rd_cfg,     // configuration readback
    input wire logic               req_valid,  // access strobe
    input wire pmp_pkg::acc_req_t  req,        // access under check
    input wire pmp_pkg::acc_resp_t resp,       // verdict
    input wire logic               resp_valid  // verdict strobe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // requests of one kind, the first step of the load and fetch verdict checks
    sequence s_load; req_valid && req.kind == pmp_pkg::ACC_LOAD; endsequence
    sequence s_fetch; req_valid && req.kind == pmp_pkg::ACC_FETCH; endsequence
    // machine load while every entry is off, so nothing can match
    sequence s_bare_m_load; s_load ##0 (req.priv == 2'h3 && !req.reserved && rd_cfg == 64'h0); endsequence
    property p_answer; req_valid |=> resp_valid; endproperty
    a_answer: assert property (p_answer) else $error("no verdict one cycle after a request");
    property p_quiet; !req_valid |=> !resp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("verdict without a request");
    property p_top_bits; rd_addr[63:54] == 10'h0; endproperty
    a_top_bits: assert property (p_top_bits) else $error("address register holds bits above 55");
    // a write from below machine mode must leave the whole group alone
    property p_low_write; csr_wr.we && cur_priv != 2'h3 |=> $stable(rd_cfg); endproperty
    a_low_write: assert property (p_low_write) else $error("non-machine write changed config");
    property p_cfg_take;
        csr_wr.we && csr_wr.is_cfg && cur_priv == 2'h3 && !rd_cfg[7]
        |=> {rd_cfg[7], rd_cfg[4:0]} == $past({csr_wr.wdata[7], csr_wr.wdata[4:0]});
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("machine write to field 0 not taken");
    property p_lock_holds; rd_cfg[23] |=> rd_cfg[23:16] == $past(rd_cfg[23:16]); endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked field 2 changed");
    property p_spec; req_valid && req.spec |=> resp.fault == pmp_pkg::FAULT_NONE; endproperty
    a_spec: assert property (p_spec) else $error("speculative fetch trapped");
    property p_load_fault; s_load |=> resp.fault inside {pmp_pkg::FAULT_NONE, pmp_pkg::FAULT_LOAD}; endproperty
    a_load_fault: assert property (p_load_fault) else $error("load raised a foreign fault");
    property p_fetch_fault; s_fetch |=> resp.fault inside {pmp_pkg::FAULT_NONE, pmp_pkg::FAULT_FETCH}; endproperty
    a_fetch_fault: assert property (p_fetch_fault) else $error("fetch raised a foreign fault");
    property p_bare_m; s_bare_m_load |=> resp.grant && resp.entry == 4'h8; endproperty
    a_bare_m: assert property (p_bare_m) else $error("unmatched machine load refused");
    property p_discard; req_valid && req.kind == pmp_pkg::ACC_DISCARD && !req.reserved |=> resp.grant; endproperty
    a_discard: assert property (p_discard) else $error("discard refused");
endmodule
bind phys_mem_protection_checker pmp_check_asserts #(.ENTRIES(ENTRIES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .cur_priv(cur_priv), .csr_wr(csr_wr), .rd_idx(rd_idx), .rd_addr(rd_addr),
    .rd_cfg(rd_cfg), .req_valid(req_valid), .req(req), .resp(resp), .resp_valid(resp_valid));
`default_nettype wire

// *** hart_pipe_model.sv ***
// behavioural hart pipeline: register writes at a given privilege and checked accesses.
// assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module hart_pipe_model (
    input  wire logic        sys_clk,    // core clock
    output var logic [1:0]   cur_priv,   // privilege the hart runs in
    output pmp_pkg::csr_wr_t csr_wr,     // register writes
    output logic             req_valid,  // access strobe
    output pmp_pkg::acc_req_t req        // access under check
);
    // idle values from time zero, machine mode out of reset
    initial
    begin
        cur_priv  = 2'h3;
        csr_wr    = '0;
        req_valid = 1'b0;
        req       = '0;
    end
    // release a standing access; fields flip so stale values never look valid
    task automatic rest();
        if (req_valid)
        begin
            req_valid = 1'b0;
            req       = ~req;
        end
    endtask
    // one register write, one cycle wide; paging is off, so no fence follows
    task automatic wr(input logic [1:0] p, input logic c, input logic [2:0] i, input logic [63:0] d);
        rest();
        @(posedge sys_clk);
        #1;
        cur_priv = p;
        csr_wr   = '{we: 1'b1, is_cfg: c, idx: i, wdata: d};
        @(posedge sys_clk);
        #1;
        csr_wr = '{we: 1'b0, is_cfg: ~c, idx: ~i, wdata: ~d};
    endtask
    // present one access; held up so consecutive calls run back to back
    task automatic issue(input pmp_pkg::acc_req_t r);
        req_valid = 1'b1;
        req       = r;
        @(posedge sys_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// *** test_phys_mem_protection_checker.sv ***
// self-checking bench for the protection checker: guarding, priority, faults, special kinds.
// assumes the hart pipeline model drives every request-side input.
`timescale 1ns/1ns
`default_nettype none
module test_phys_mem_protection_checker;
    logic               sys_clk = 1'b0;  // core clock
    logic               rst = 1'b1;      // sync reset
    logic [1:0]         cur_priv;        // from model
    pmp_pkg::csr_wr_t   csr_wr;          // from model
    logic [2:0]         rd_idx = 3'h0;   // readback select
    logic [63:0]        rd_addr;         // address readback
    logic [63:0]        rd_cfg;          // config readback
    logic               req_valid;       // access strobe
    pmp_pkg::acc_req_t  req;             // access
    pmp_pkg::acc_resp_t resp;            // verdict
    logic               resp_valid;      // verdict strobe
    int                 errors = 0;      // mismatches
    int                 n_tests = 0;     // comparisons
    int                 seed = 19474;    // random seed
    logic [55:0]        ra;              // random address
    logic [8:0]         cur_m;           // mask of the verdict under compare
    logic [8:0]         exp_q[$];        // expected verdicts {grant, fault, zero_read, bus_error, entry}
    logic [8:0]         msk_q[$];        // fields compared per verdict
    localparam logic [8:0] ALL = 9'h1FF; // whole verdict
    localparam logic [8:0] NOE = 9'h1F0; // entry not compared
    always #5 sys_clk = ~sys_clk;
    hart_pipe_model u_hart (.sys_clk(sys_clk), .cur_priv(cur_priv), .csr_wr(csr_wr), .req_valid(req_valid), .req(req));
    phys_mem_protection_checker #(.ENTRIES(8)) u_dut (.sys_clk(sys_clk), .rst(rst), .cur_priv(cur_priv),
        .csr_wr(csr_wr), .rd_idx(rd_idx), .rd_addr(rd_addr), .rd_cfg(rd_cfg), .req_valid(req_valid),
        .req(req), .resp(resp), .resp_valid(resp_valid));
    // one comparison, counted; a mismatch is reported at once
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
        n_tests++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // readback of one address register, then back onto the drive edge
    task automatic rd(input logic [2:0] i, input logic [63:0] w);
        rd_idx = i;
        #1;
        check("addr reg", rd_addr, w);
        @(posedge sys_clk);
        #1;
    endtask
    // kind codes follow the package order: 0 load 1 store 2 fetch 3 walk 4 flush 5 discard
    task automatic acc(input logic [1:0] p, input logic [2:0] k, input logic [55:0] a, input logic [6:0] n,
                       input logic [2:0] f, input logic [8:0] e, input logic [8:0] m);
        pmp_pkg::acc_req_t r;
        r = '{paddr: a, size_m1: n, kind: pmp_pkg::acc_kind_t'(k), priv: p, spec: f[2], reserved: f[1], in_device: f[0]};
        exp_q.push_back(e);
        msk_q.push_back(m);
        u_hart.issue(r);
    endtask
    // oldest note against each verdict, sampled mid-cycle once it has settled
    always @(negedge sys_clk)
    begin
        if (resp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("extra verdict", 64'h1, 64'h0);
            else
            begin
                cur_m = msk_q.pop_front();
                check("verdict", 64'(resp & cur_m), 64'(exp_q.pop_front() & cur_m));
            end
        end
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 8; i++)
            rd(i[2:0], 64'h0);
        check("cfg group", rd_cfg, 64'h0);
        acc(2'h3, 3'h0, 56'h5000, 7'h3, 3'h0, 9'h108, ALL);
        u_hart.wr(2'h0, 1'b0, 3'h0, 64'h403);
        rd(3'h0, 64'h0);
        u_hart.wr(2'h3, 1'b0, 3'h7, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(3'h7, 64'h003F_FFFF_FFFF_FFFF);
        // entry 0: 64 bytes at 1000 read only; entry 1: 256 bytes at 1000 all; entry 2: 32 bytes at 2000 locked read
        u_hart.wr(2'h3, 1'b0, 3'h0, 64'h407);
        u_hart.wr(2'h3, 1'b0, 3'h1, 64'h41F);
        u_hart.wr(2'h3, 1'b0, 3'h2, 64'h803);
        rd(3'h2, 64'h803);
        u_hart.wr(2'h3, 1'b1, 3'h0, 64'h0000_0000_0099_1F19);
        check("cfg group", rd_cfg, 64'h0000_0000_0099_1F19);
        acc(2'h0, 3'h0, 56'h1000, 7'h3, 3'h0, 9'h100, ALL);
        acc(2'h0, 3'h1, 56'h1000, 7'h3, 3'h0, 9'h080, ALL);
        acc(2'h0, 3'h2, 56'h1000, 7'h3, 3'h0, 9'h0C0, ALL);
        acc(2'h0, 3'h1, 56'h103C, 7'h3, 3'h0, 9'h080, ALL);
        acc(2'h0, 3'h1, 56'h1040, 7'h3, 3'h0, 9'h101, ALL);
        acc(2'h0, 3'h0, 56'h103C, 7'h7, 3'h0, 9'h040, ALL);
        acc(2'h3, 3'h0, 56'h103C, 7'h7, 3'h0, 9'h040, ALL);
        acc(2'h3, 3'h1, 56'h1000, 7'h3, 3'h0, 9'h100, ALL);
        acc(2'h3, 3'h1, 56'h2000, 7'h3, 3'h0, 9'h082, ALL);
        acc(2'h1, 3'h0, 56'h2000, 7'h3, 3'h0, 9'h102, ALL);
        acc(2'h0, 3'h0, 56'h5000, 7'h3, 3'h0, 9'h048, ALL);
        acc(2'h3, 3'h3, 56'h5000, 7'h7, 3'h0, 9'h048, ALL);
        acc(2'h0, 3'h2, 56'h1000, 7'h3, 3'h4, 9'h000, ALL);
        acc(2'h3, 3'h4, 56'h1FE0, 7'h3F, 3'h0, 9'h080, NOE);
        acc(2'h3, 3'h4, 56'h1F80, 7'h3F, 3'h0, 9'h100, NOE);
        acc(2'h3, 3'h5, 56'h2000, 7'h3F, 3'h0, 9'h100, NOE);
        acc(2'h3, 3'h0, 56'h5000, 7'h3, 3'h3, 9'h020, 9'h020);
        acc(2'h3, 3'h0, 56'h5000, 7'h3, 3'h2, 9'h010, 9'h110);
        // random back-to-back loads across both overlapping entries
        for (int i = 0; i < 16; i++)
        begin
            ra = 56'h1000 + 56'({$random(seed)} % 64) * 56'h4;
            acc(2'h0, 3'h0, ra, 7'h3, 3'h0, (ra < 56'h1040) ? 9'h100 : 9'h101, ALL);
        end
        u_hart.wr(2'h3, 1'b0, 3'h2, 64'h0);
        rd(3'h2, 64'h803);
        u_hart.wr(2'h3, 1'b1, 3'h0, 64'h0000_0000_0000_1F1B);
        acc(2'h0, 3'h1, 56'h1000, 7'h3, 3'h0, 9'h100, ALL);
        check("cfg group", rd_cfg, 64'h0000_0000_0099_1F1B);
        u_hart.rest();
        for (int i = 0; i < 10 && exp_q.size() > 0; i++)
            @(posedge sys_clk);
        if (exp_q.size() > 0)
            check("pending verdicts", 64'(exp_q.size()), 64'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
